/* File: rtl/mbp_defs.vh */
// Purpose: Constants for the MAC back-off, retry, broadcast reject and pad strip block
// Assumes: 100 MHz system clock, 100 Mb/s medium, plain register port
// Notes:   All offsets, fields, reset values and timing counts live here
//
// Summary of operation
// - Broadcast reject set: received broadcast frames are discarded, never delivered.
// - Retries disabled: one attempt; on collision drop frame, move on, flag retry error.
// - Retries enabled: up to 16 attempts, then abandon frame and flag retry error.
// - Pad strip on, length field below 46: remove pad bytes and FCS.
// - Pad strip on, length field 46 or more: frame passes unchanged with FCS.
// - Pad strip off: every frame passes unmodified.
// - After collision wait r slot times, 0 <= r < 2^K, K = min(retries, 10).
// - Random back-off value comes from a 20-bit LFSR counter.
// - Load lowest K LFSR bits, count down once per slot time to zero.
// - Two-bit back-off limit field, bits 7-6, caps number of LFSR bits used.
// - Limit field caps bits: 00 gives 10, 01 gives 8, 10 gives 4, 11 gives 1.
`ifndef MBP_DEFS_VH
`define MBP_DEFS_VH

// Register offsets (word index on the plain port)
`define MBP_REG_CTRL        4'h0
`define MBP_REG_STATUS      4'h1
`define MBP_REG_MASK        4'h2
`define MBP_REG_STATE       4'h3
`define MBP_REG_LFSR        4'h4

// Control register fields
`define MBP_CTRL_RESET      32'h0000_0000
`define MBP_CTRL_BROADCAST_REJECT_BIT  11
`define MBP_CTRL_RETRY_BIT  10
`define MBP_CTRL_PAD_BIT    8
`define MBP_CTRL_BOL_HI     7
`define MBP_CTRL_BOL_LO     6

// Status / mask bits
`define MBP_ST_TX_DONE      0
`define MBP_ST_RETRY_ERR    1
`define MBP_ST_BROADCAST_REJECT_DROP   2
`define MBP_ST_COLL         3
`define MBP_ST_W            4

// Retry, back-off and pad strip figures
`define MBP_MAX_ATTEMPTS    5'd16
`define MBP_K_CAP           4'd10
`define MBP_LFSR_W          20
`define MBP_LFSR_SEED       20'h00001
`define MBP_MIN_LEN         16'd46
`define MBP_FCS_BYTES       5'd4
`define MBP_HDR_BYTES       16'd14

// Slot time: 512 bit times at 100 Mb/s = 5120 ns
`define MBP_SLOT_NS         5120
`define MBP_CLK_NS          10
`define MBP_SLOT_CYC        (`MBP_SLOT_NS / `MBP_CLK_NS)
// Last divider count of a slot, sized for the 13-bit divider
`define MBP_SLOT_LAST       13'd511

`endif

/* File: rtl/mbp_lfsr.v */
// Purpose: 20-bit free-running LFSR, random source for collision back-off
// Assumes: One system clock, synchronous active-high reset
// Notes:   Taps 20,17 give a maximal sequence; all-zero state is never entered
`timescale 1ns/1ps
`include "mbp_defs.vh"

module mbp_lfsr (
  input  wire                    sys_clk_in, // System clock
  input  wire                    rst_in,     // Synchronous reset
  output wire [`MBP_LFSR_W-1:0]  value_out   // Current LFSR state
);

  reg [`MBP_LFSR_W-1:0] lfsr_q;

  // Advance every cycle so the draw depends on collision timing
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
      lfsr_q <= `MBP_LFSR_SEED;
    else
      lfsr_q <= {lfsr_q[18:0], lfsr_q[19] ^ lfsr_q[16]};
  end

  assign value_out = lfsr_q;

endmodule

/* File: rtl/mbp_mac_ctrl.v */
// Purpose: Transmit retry policy, collision back-off, broadcast reject and pad strip
// Assumes: Transmit engine and receive byte stream on the system clock
// Notes:   Receive path is a byte stream delayed seven cycles, rejected frames dropped whole
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "mbp_defs.vh"

module mbp_mac_ctrl (
  input  wire        sys_clk_in,      // System clock, 100 MHz
  input  wire        rst_in,          // Synchronous reset, active high
  // Register port
  input  wire [3:0]  reg_addr_in,     // Register word index
  input  wire [31:0] reg_wdata_in,    // Write data
  input  wire        reg_wr_in,       // Write strobe
  input  wire        reg_rd_in,       // Read strobe
  output wire [31:0] reg_rdata_out,   // Read data, cycle after strobe
  output wire        irq_out,         // Level interrupt
  // Transmit attempt handshake
  input  wire        tx_req_in,       // Frame queued for sending
  output wire        tx_start_out,    // Pulse: start an attempt
  input  wire        tx_done_in,      // Pulse: attempt finished cleanly
  input  wire        tx_coll_in,      // Pulse: attempt collided
  output wire        tx_next_out,     // Pulse: frame retired, fetch next
  output wire        tx_retry_err_out,// Pulse: frame abandoned
  output wire        backoff_out,     // Waiting in back-off
  // Receive byte stream in
  input  wire        rx_valid_in,     // Byte valid
  input  wire [7:0]  rx_data_in,      // Byte
  input  wire        rx_sof_in,       // First byte of frame
  input  wire        rx_eof_in,       // Last byte of frame
  // Receive byte stream out
  output wire        rx_valid_out,    // Byte valid
  output wire [7:0]  rx_data_out,     // Byte
  output wire        rx_sof_out,      // First delivered byte
  output wire        rx_eof_out       // Last delivered byte
);

  // Transmit states
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_SEND = 2'd1;
  localparam [1:0] ST_BACK = 2'd2;

  reg  [31:0]          ctrl_q;
  reg  [`MBP_ST_W-1:0] stat_q;
  reg  [`MBP_ST_W-1:0] stat_d;
  reg  [`MBP_ST_W-1:0] mask_q;
  reg  [31:0]          rdata_q;
  reg  [1:0]           state_q;
  reg  [4:0]           tries_q;
  reg                  start_q;
  reg                  next_q;
  reg                  err_q;
  reg                  bo_start_q;
  reg  [9:0]           bo_cnt_q;
  wire [19:0]          lfsr;
  wire                 bo_busy;
  wire                 bo_done;
  wire                 broadcast_reject_rej;
  wire                 retry_en;
  wire                 pad_en;
  wire [1:0]           bol_sel;

  assign broadcast_reject_rej = ctrl_q[`MBP_CTRL_BROADCAST_REJECT_BIT];
  assign retry_en  = ctrl_q[`MBP_CTRL_RETRY_BIT];
  assign pad_en    = ctrl_q[`MBP_CTRL_PAD_BIT];
  assign bol_sel   = ctrl_q[`MBP_CTRL_BOL_HI:`MBP_CTRL_BOL_LO];

  // Back-off exponent: min(retries, 10), then capped by the limit field
  function [3:0] bo_bits;
    input [4:0] tries;
    input [1:0] sel;
    reg   [3:0] k;
    reg   [3:0] cap;
    begin
      k = (tries > 5'd10) ? `MBP_K_CAP : tries[3:0];
      case (sel)
        2'b00:   cap = 4'd10;
        2'b01:   cap = 4'd8;
        2'b10:   cap = 4'd4;
        default: cap = 4'd1;
      endcase
      bo_bits = (k < cap) ? k : cap;
    end
  endfunction

  // Lowest K bits of the LFSR, so 0 <= r < 2^K
  function [9:0] low_bits;
    input [19:0] v;
    input [3:0]  n;
    begin
      low_bits = v[9:0] & ((10'h001 << n) - 10'h001);
    end
  endfunction

  mbp_lfsr mbp_lfsr_i (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .value_out  (lfsr)
  );

  mbp_slot_timer mbp_slot_timer_i (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .start_in   (bo_start_q),
    .count_in   (bo_cnt_q),
    .busy_out   (bo_busy),
    .done_out   (bo_done)
  );

  // Transmit attempt sequencer
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      state_q    <= ST_IDLE;
      tries_q    <= 5'd0;
      start_q    <= 1'b0;
      next_q     <= 1'b0;
      err_q      <= 1'b0;
      bo_start_q <= 1'b0;
      bo_cnt_q   <= 10'h000;
    end
    else
    begin
      start_q    <= 1'b0;
      next_q     <= 1'b0;
      err_q      <= 1'b0;
      bo_start_q <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (tx_req_in && !next_q)
          begin
            tries_q <= 5'd1;
            start_q <= 1'b1;
            state_q <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          if (tx_done_in)
          begin
            next_q  <= 1'b1;
            state_q <= ST_IDLE;
          end
          else if (tx_coll_in)
          begin
            if (!retry_en || tries_q == `MBP_MAX_ATTEMPTS)
            begin
              next_q  <= 1'b1;
              err_q   <= 1'b1;
              state_q <= ST_IDLE;
            end
            else
            begin
              bo_cnt_q   <= low_bits(lfsr, bo_bits(tries_q, bol_sel));
              bo_start_q <= 1'b1;
              state_q    <= ST_BACK;
            end
          end
        end
        ST_BACK:
        begin
          if (bo_done)
          begin
            tries_q <= tries_q + 5'd1;
            start_q <= 1'b1;
            state_q <= ST_SEND;
          end
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  assign tx_start_out     = start_q;
  assign tx_next_out      = next_q;
  assign tx_retry_err_out = err_q;
  assign backoff_out      = bo_busy;

  // Receive path: six-stage delay so the whole destination is seen before byte 0 leaves
  reg  [5:0]  pv_q;
  reg  [5:0]  ps_q;
  reg  [5:0]  pe_q;
  reg  [7:0]  pd_q [0:5];
  reg  [15:0] rx_idx_q;
  reg         rx_drop_q;
  reg         rx_strip_q;
  reg  [15:0] rx_keep_q;
  reg  [7:0]  rx_len_hi_q;
  reg         ov_q;
  reg  [7:0]  od_q;
  reg         osof_q;
  reg         oeof_q;
  reg         bc_evt_q;
  wire [15:0] idx;
  wire        all_ff;
  wire        drop;
  wire [15:0] len_val;
  wire        len_short;
  wire        pass;
  wire        cut_end;
  integer     i;

  // Oldest stage is the byte being judged; a start byte restarts the position
  assign idx       = ps_q[5] ? 16'h0000 : rx_idx_q;
  // Limitation: the six destination bytes must arrive back to back
  assign all_ff    = (&pv_q) && (pd_q[0] == 8'hff) && (pd_q[1] == 8'hff) && (pd_q[2] == 8'hff)
                     && (pd_q[3] == 8'hff) && (pd_q[4] == 8'hff) && (pd_q[5] == 8'hff);
  assign drop      = ps_q[5] ? (broadcast_reject_rej && all_ff) : rx_drop_q;
  // Length field is bytes 12 and 13, judged as byte 13 leaves
  assign len_val   = {rx_len_hi_q, pd_q[5]};
  assign len_short = pad_en && (idx == 16'd13) && (len_val < `MBP_MIN_LEN);

  // Byte is delivered if the frame is kept and lies inside the kept length
  assign pass      = !drop && (!rx_strip_q || idx < rx_keep_q);
  // A zero length ends the frame on the length field itself
  assign cut_end   = (rx_strip_q && idx == rx_keep_q - 16'h0001) || (len_short && len_val == 16'h0000);

  // Delay line shifts every cycle, so a frame's tail drains without more input
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      pv_q <= 6'h00;
      ps_q <= 6'h00;
      pe_q <= 6'h00;
      for (i = 0; i < 6; i = i + 1)
        pd_q[i] <= 8'h00;
    end
    else
    begin
      pv_q    <= {pv_q[4:0], rx_valid_in};
      ps_q    <= {ps_q[4:0], rx_valid_in && rx_sof_in};
      pe_q    <= {pe_q[4:0], rx_valid_in && rx_eof_in};
      pd_q[0] <= rx_data_in;
      for (i = 1; i < 6; i = i + 1)
        pd_q[i] <= pd_q[i - 1];
    end
  end

  // Output stage: the verdict is kept per frame, so a following frame cannot disturb a tail
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      rx_idx_q    <= 16'h0000;
      rx_drop_q   <= 1'b0;
      rx_strip_q  <= 1'b0;
      rx_keep_q   <= 16'hffff;
      rx_len_hi_q <= 8'h00;
      ov_q        <= 1'b0;
      od_q        <= 8'h00;
      osof_q      <= 1'b0;
      oeof_q      <= 1'b0;
      bc_evt_q    <= 1'b0;
    end
    else
    begin
      ov_q     <= 1'b0;
      osof_q   <= 1'b0;
      oeof_q   <= 1'b0;
      bc_evt_q <= 1'b0;
      if (pv_q[5])
      begin
        rx_idx_q <= idx + 16'h0001;
        if (ps_q[5])
        begin
          rx_drop_q  <= drop;
          bc_evt_q   <= drop;
          rx_strip_q <= 1'b0;
          rx_keep_q  <= 16'hffff;
        end
        if (idx == 16'd12)
          rx_len_hi_q <= pd_q[5];
        // Short length field: trim pad and FCS, else keep the whole frame
        if (len_short)
        begin
          rx_strip_q <= 1'b1;
          rx_keep_q  <= `MBP_HDR_BYTES + len_val;
        end
        if (pass)
        begin
          ov_q   <= 1'b1;
          od_q   <= pd_q[5];
          osof_q <= ps_q[5];
          oeof_q <= pe_q[5] || cut_end;
        end
      end
    end
  end

  assign rx_valid_out = ov_q;
  assign rx_data_out  = od_q;
  assign rx_sof_out   = osof_q;
  assign rx_eof_out   = oeof_q;

  // Sticky status, set wins over write-one-to-clear
  always @*
  begin
    stat_d = stat_q;
    if (reg_wr_in && reg_addr_in == `MBP_REG_STATUS)
      stat_d = stat_q & ~reg_wdata_in[`MBP_ST_W-1:0];
    if (next_q && !err_q)
      stat_d[`MBP_ST_TX_DONE] = 1'b1;
    if (err_q)
      stat_d[`MBP_ST_RETRY_ERR] = 1'b1;
    if (bc_evt_q)
      stat_d[`MBP_ST_BROADCAST_REJECT_DROP] = 1'b1;
    if (bo_start_q)
      stat_d[`MBP_ST_COLL] = 1'b1;
  end

  // Register writes and registered read data
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      ctrl_q  <= `MBP_CTRL_RESET;
      stat_q  <= {`MBP_ST_W{1'b0}};
      mask_q  <= {`MBP_ST_W{1'b0}};
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      stat_q <= stat_d;
      if (reg_wr_in && reg_addr_in == `MBP_REG_CTRL)
        ctrl_q <= reg_wdata_in & 32'h0000_0dc0;
      if (reg_wr_in && reg_addr_in == `MBP_REG_MASK)
        mask_q <= reg_wdata_in[`MBP_ST_W-1:0];
      rdata_q <= 32'h0000_0000;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          `MBP_REG_CTRL:   rdata_q <= ctrl_q;
          `MBP_REG_STATUS: rdata_q <= {28'h0000000, stat_q};
          `MBP_REG_MASK:   rdata_q <= {28'h0000000, mask_q};
          `MBP_REG_STATE:  rdata_q <= {16'h0000, bo_cnt_q, tries_q, bo_busy};
          `MBP_REG_LFSR:   rdata_q <= {12'h000, lfsr};
          default:         rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign irq_out       = |(stat_q & mask_q);

endmodule

/* File: rtl/mbp_slot_timer.v */
// Purpose: Slot-time tick divider and back-off countdown
// Assumes: start_in pulses with a loaded count; tick is a one-cycle enable
// Notes:   A zero count finishes one cycle after start, with no slot wait
`timescale 1ns/1ps
`include "mbp_defs.vh"

module mbp_slot_timer (
  input  wire        sys_clk_in, // System clock
  input  wire        rst_in,     // Synchronous reset
  input  wire        start_in,   // Load count and begin waiting
  input  wire [9:0]  count_in,   // Slot times to wait
  output wire        busy_out,   // Waiting
  output wire        done_out    // One-cycle pulse when wait ends
);

  reg  [12:0] div_q;
  reg  [9:0]  cnt_q;
  reg         busy_q;
  reg         done_q;
  wire        tick;

  // Slot divider restarts on start so the first slot is a full one
  assign tick = (div_q == `MBP_SLOT_LAST);

  always @(posedge sys_clk_in)
  begin
    if (rst_in)
      div_q <= 13'h0000;
    else if (start_in || tick)
      div_q <= 13'h0000;
    else
      div_q <= div_q + 13'h0001;
  end

  // Countdown: one decrement per slot time until zero
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      cnt_q  <= 10'h000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= 1'b0;
      if (start_in)
      begin
        cnt_q  <= count_in;
        busy_q <= 1'b1;
      end
      else if (busy_q && cnt_q == 10'h000)
      begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
      else if (busy_q && tick)
        cnt_q <= cnt_q - 10'h001;
    end
  end

  assign busy_out = busy_q;
  assign done_out = done_q;

endmodule

/* File: tb/mbp_mac_ctrl_checker.sv */
// Purpose: Port-level assertions for retry, back-off, broadcast reject and pad strip
// Assumes: Control word shadowed from writes to word 0; frames arrive as unbroken runs
// Notes:   Back-off bound allows a few handshake cycles beyond whole slots
`timescale 1ns/1ps
module mbp_mac_ctrl_checker (
  input wire        sys_clk_in,       // Clock
  input wire        rst_in,           // Reset
  input wire [3:0]  reg_addr_in,      // Register index
  input wire [31:0] reg_wdata_in,     // Write data
  input wire        reg_wr_in,        // Write strobe
  input wire        tx_start_out,     // Attempt start
  input wire        tx_done_in,       // Attempt finished
  input wire        tx_coll_in,       // Attempt collided
  input wire        tx_next_out,      // Frame retired
  input wire        tx_retry_err_out, // Frame abandoned
  input wire        backoff_out,      // Back-off running
  input wire        rx_valid_in,      // Byte in valid
  input wire [7:0]  rx_data_in,       // Byte in
  input wire        rx_sof_in,        // First byte in
  input wire        rx_eof_in,        // Last byte in
  input wire        rx_valid_out,     // Byte out valid
  input wire        rx_eof_out        // Last byte out
);
  reg  [11:0] ctrl_q;
  reg  [4:0]  tries_q;
  reg  [3:0]  k_q;
  reg  [19:0] bo_q;
  reg  [15:0] idx_q;
  reg  [15:0] len_q;
  reg         ff_q;
  wire [15:0] idx  = rx_sof_in ? 16'h0000 : idx_q;
  wire [3:0]  cap  = (ctrl_q[7:6] == 2'b00) ? 4'ha : (ctrl_q[7:6] == 2'b01) ? 4'h8 : (ctrl_q[7:6] == 2'b10) ? 4'h4 : 4'h1;
  wire [3:0]  kt   = (tries_q > 5'h0a) ? 4'ha : tries_q[3:0];
  wire        drop = ctrl_q[11] && ff_q;
  // Shadow state: control bits, attempts so far, back-off length, receive position
  always @(posedge sys_clk_in)
  begin
    if (rst_in)
    begin
      ctrl_q  <= 12'h000;
      tries_q <= 5'h00;
      k_q     <= 4'h0;
      bo_q    <= 20'h00000;
      idx_q   <= 16'h0000;
      len_q   <= 16'h0000;
      ff_q    <= 1'b0;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == 4'h0)
        ctrl_q <= reg_wdata_in[11:0];
      if (tx_next_out)
        tries_q <= 5'h00;
      else if (tx_start_out)
        tries_q <= tries_q + 5'h01;
      if (tx_coll_in)
        k_q <= (kt < cap) ? kt : cap;
      bo_q <= backoff_out ? bo_q + 20'h00001 : 20'h00000;
      if (rx_valid_in)
        idx_q <= idx + 16'h0001;
      if (rx_valid_in && idx < 16'h0006)
        ff_q <= (rx_sof_in || ff_q) && rx_data_in == 8'hff;
      if (rx_valid_in && idx == 16'h000c)
        len_q[15:8] <= rx_data_in;
      if (rx_valid_in && idx == 16'h000d)
        len_q[7:0] <= rx_data_in;
    end
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // Six all-ones destination bytes in a row
  sequence s_broadcast_reject;
    rx_valid_in && rx_sof_in && rx_data_in == 8'hff ##1 (rx_valid_in && rx_data_in == 8'hff)[*5];
  endsequence
  sequence s_abandon;
    tx_next_out && tx_retry_err_out;
  endsequence
  AST_BROADCAST_REJECT_DROP: assert property (ctrl_q[11] ##0 s_broadcast_reject |=> (!rx_valid_out)[*8])
    else $error("broadcast byte delivered");
  AST_NORETRY_DROP: assert property (tx_coll_in && !ctrl_q[10] |=> s_abandon)
    else $error("single attempt collision not abandoned");
  AST_DONE_NEXT: assert property (tx_done_in |=> tx_next_out && !tx_retry_err_out)
    else $error("clean attempt not retired");
  AST_RETRY_LAST: assert property (tx_coll_in && ctrl_q[10] && tries_q == 5'h10 |=> s_abandon)
    else $error("sixteenth collision not abandoned");
  AST_RETRY_MORE: assert property (tx_coll_in && ctrl_q[10] && tries_q < 5'h10 |=> !tx_next_out ##[0:2] backoff_out)
    else $error("early collision not followed by back-off");
  AST_BACKOFF_LEN: assert property (backoff_out |-> bo_q < (((20'h00001 << k_q) - 20'h00001) << 9) + 20'h00008)
    else $error("back-off longer than allowed slots");
  AST_BACKOFF_EXIT: assert property ($fell(backoff_out) |-> ##[0:4] tx_start_out)
    else $error("no attempt after back-off");
  AST_NO_START_IN_BACKOFF: assert property (backoff_out |-> !tx_start_out)
    else $error("attempt during back-off");
  AST_PAD_EOF: assert property (ctrl_q[8] && rx_valid_in && !drop && idx >= 16'h000e && len_q < 16'h002e
    && idx == len_q + 16'h000d |-> ##7 rx_valid_out && rx_eof_out)
    else $error("padded frame not cut after length field");
  AST_PASS_EOF: assert property (rx_valid_in && rx_eof_in && !drop && (!ctrl_q[8] || len_q >= 16'h002e) |-> ##7 rx_eof_out)
    else $error("frame end not passed through");
endmodule
bind mbp_mac_ctrl mbp_mac_ctrl_checker mbp_mac_ctrl_checker_i (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .tx_start_out, .tx_done_in, .tx_coll_in, .tx_next_out, .tx_retry_err_out, .backoff_out,
  .rx_valid_in, .rx_data_in, .rx_sof_in, .rx_eof_in, .rx_valid_out, .rx_eof_out);

/* File: tb/mbp_mac_ctrl_tb.sv */
// Purpose: Self-checking bench for retry policy, back-off, broadcast reject and pad strip
// Assumes: Medium model answers attempts; receive frames are 64-byte runs driven here
// Notes:   Long retry runs use a small back-off limit so slot waits stay short
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares = compares + 1; if ((g) !== (e)) begin failures = failures + 1; \
  $display("wrong value %s expected %0h seen %0h", n, e, g); end end
module mbp_mac_ctrl_tb;
  reg         sys_clk_in   = 1'b0;
  reg         rst_in       = 1'b1;
  reg  [3:0]  reg_addr_in  = 4'h0;
  reg  [31:0] reg_wdata_in = 32'h0;
  reg         reg_wr_in    = 1'b0;
  reg         reg_rd_in    = 1'b0;
  reg         tx_req_in    = 1'b0;
  reg         rx_valid_in  = 1'b0;
  reg  [7:0]  rx_data_in   = 8'h00;
  reg         rx_sof_in    = 1'b0;
  reg         rx_eof_in    = 1'b0;
  reg  [7:0]  colls        = 8'h00;
  reg  [7:0]  dly          = 8'h02;
  wire [31:0] reg_rdata_out;
  wire        irq_out, tx_start_out, tx_done_in, tx_coll_in, tx_next_out, tx_retry_err_out, backoff_out;
  wire        rx_valid_out, rx_sof_out, rx_eof_out;
  wire [7:0]  rx_data_out;
  reg  [31:0] d, e;
  integer     failures = 0;
  integer     compares = 0;
  integer     starts   = 0;
  integer     nout     = 0;
  integer     sofs     = 0;
  reg  [7:0]  firstb   = 8'h00;
  reg  [7:0]  lastb    = 8'h00;
  mbp_mac_ctrl mbp_mac_ctrl_i (.sys_clk_in, .rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .irq_out, .tx_req_in, .tx_start_out, .tx_done_in, .tx_coll_in, .tx_next_out,
    .tx_retry_err_out, .backoff_out, .rx_valid_in, .rx_data_in, .rx_sof_in, .rx_eof_in, .rx_valid_out,
    .rx_data_out, .rx_sof_out, .rx_eof_out);
  mbp_phy_model mbp_phy_model_i (.sys_clk_in(sys_clk_in), .start_in(tx_start_out), .next_in(tx_next_out),
    .colls_in(colls), .dly_in(dly), .done_out(tx_done_in), .coll_out(tx_coll_in));
  // Clock, attempt tally and delivered byte tally
  always #5 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in)
  begin
    if (tx_start_out === 1'b1)
      starts = starts + 1;
    if (rx_valid_out === 1'b1)
    begin
      nout = nout + 1;
      if (rx_sof_out === 1'b1)
      begin
        sofs = sofs + 1;
        firstb = rx_data_out;
      end
      if (rx_eof_out === 1'b1)
        lastb = rx_data_out;
    end
  end
  task wr(input [3:0] a, input [31:0] v);
  begin
    @(posedge sys_clk_in);
    reg_addr_in  <= a;
    reg_wdata_in <= v;
    reg_wr_in    <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
  end
  endtask
  // Read data stands only in the cycle after the strobe
  task rd(input [3:0] a, output [31:0] v);
  begin
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  end
  endtask
  // Queue one frame, wait bounded for retirement, judge attempts and error
  task txframe(input integer n, input err);
    integer t;
  begin
    starts = 0;
    t = 0;
    @(posedge sys_clk_in);
    tx_req_in <= 1'b1;
    while (tx_next_out !== 1'b1 && t < 20000)
    begin
      @(posedge sys_clk_in);
      t = t + 1;
    end
    tx_req_in <= 1'b0;
    `CHK("retired", 1'b1, tx_next_out)
    `CHK("retry error", err, tx_retry_err_out)
    `CHK("attempts", n, starts)
    repeat (2) @(posedge sys_clk_in);
  end
  endtask
  // Send a 64-byte frame under a control word and count what comes out
  task rxchk(input [31:0] c, input bc, input [15:0] len, input integer exp);
    integer i;
  begin
    wr(4'h0, c);
    nout = 0;
    sofs = 0;
    firstb = 8'h00;
    lastb = 8'h00;
    for (i = 0; i < 64; i = i + 1)
    begin
      @(posedge sys_clk_in);
      rx_valid_in <= 1'b1;
      rx_sof_in   <= (i == 0);
      rx_eof_in   <= (i == 63);
      rx_data_in  <= (bc && i < 6) ? 8'hff : (i == 12) ? len[15:8] : (i == 13) ? len[7:0] : i[7:0];
    end
    @(posedge sys_clk_in);
    rx_valid_in <= 1'b0;
    rx_eof_in   <= 1'b0;
    repeat (9) @(posedge sys_clk_in);
    `CHK("bytes out", exp, nout)
    `CHK("frame starts", exp > 0, sofs)
    `CHK("first byte", (exp > 0 && bc) ? 8'hff : 8'h00, firstb)
    `CHK("last byte", (exp > 0) ? exp - 1 : 0, lastb)
  end
  endtask
  task t_regs;
  begin
    rd(4'h0, d);
    `CHK("ctrl reset", 32'h0000_0000, d)
    wr(4'h0, 32'hffff_ffff);
    rd(4'h0, d);
    `CHK("ctrl bits", 32'h0000_0dc0, d)
    rd(4'h7, d);
    `CHK("unmapped", 32'h0000_0000, d)
    rd(4'h3, d);
    `CHK("state idle", 32'h0000_0000, d)
    rd(4'h4, d);
    rd(4'h4, e);
    `CHK("lfsr moves", 1'b1, d !== e)
  end
  endtask
  // Single attempt: clean send, then a collision that raises the interrupt
  task t_noretry;
  begin
    wr(4'h0, 32'h0000_0000);
    wr(4'h1, 32'h0000_000f);
    wr(4'h2, 32'h0000_0002);
    colls = 8'h00;
    txframe(1, 1'b0);
    colls = 8'h01;
    txframe(1, 1'b1);
    rd(4'h1, d);
    `CHK("error status", 1'b1, d[1])
    `CHK("done status", 1'b1, d[0])
    `CHK("irq raised", 1'b1, irq_out)
    wr(4'h1, 32'h0000_0002);
    @(posedge sys_clk_in);
    #1 `CHK("irq cleared", 1'b0, irq_out)
    wr(4'h2, 32'h0000_0000);
  end
  endtask
  // Retries: abandon after sixteen, then succeed on the fourth with slow answers
  task t_retry;
  begin
    wr(4'h0, 32'h0000_05c0);
    colls = 8'h63;
    txframe(16, 1'b1);
    rd(4'h1, d);
    `CHK("collision status", 1'b1, d[3])
    wr(4'h0, 32'h0000_0480);
    colls = 8'h03;
    dly = 8'h14;
    txframe(4, 1'b0);
  end
  endtask
  task t_rx;
  begin
    rxchk(32'h0000_0800, 1'b1, 16'h002e, 0);
    rd(4'h1, d);
    `CHK("drop status", 1'b1, d[2])
    rxchk(32'h0000_0000, 1'b1, 16'h002e, 64);
    rxchk(32'h0000_0100, 1'b0, 16'h000a, 24);
    rxchk(32'h0000_0100, 1'b0, 16'h002d, 59);
    rxchk(32'h0000_0100, 1'b0, 16'h002e, 64);
    rxchk(32'h0000_0000, 1'b0, 16'h000a, 64);
  end
  endtask
  task summarize;
  begin
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  // Watchdog well beyond the longest expected run of some fifteen thousand cycles
  initial
  begin
    #900_000;
    failures = failures + 1;
    summarize;
  end
  initial
  begin
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_regs;
    t_noretry;
    t_retry;
    t_rx;
    summarize;
  end
endmodule

/* File: tb/mbp_phy_model.sv */
// Purpose: Medium model answering each transmit attempt with a collision or a finish
// Assumes: One attempt in flight; answer comes dly_in cycles after the start pulse
// Notes:   Collision tally restarts when the block retires a frame
`timescale 1ns/1ps
module mbp_phy_model (
  input  wire       sys_clk_in, // Clock
  input  wire       start_in,   // Attempt start
  input  wire       next_in,    // Frame retired
  input  wire [7:0] colls_in,   // Colliding attempts per frame
  input  wire [7:0] dly_in,     // Answer delay
  output reg        done_out,   // Clean finish pulse
  output reg        coll_out    // Collision pulse
);
  integer n = 0;
  initial
  begin
    done_out = 1'b0;
    coll_out = 1'b0;
  end
  // One-cycle answers launched after an edge; slow answers hold the block longer
  always @(posedge sys_clk_in)
  begin
    if (next_in)
      n = 0;
    if (start_in)
    begin
      repeat (dly_in) @(posedge sys_clk_in);
      coll_out <= (n < colls_in);
      done_out <= (n >= colls_in);
      n = n + 1;
      @(posedge sys_clk_in);
      coll_out <= 1'b0;
      done_out <= 1'b0;
    end
  end
endmodule
